// ===== core/dma_tx_pkg.sv
// Shared constants and types for the serial-transmit DMA channel.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package dma_tx_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [23:0] SRC_ADDR_OFS   = 24'hfffc00; // Source address.
  localparam logic [23:0] DST_ADDR_OFS   = 24'hfffc04; // Destination address.
  localparam logic [23:0] COUNT_OFS      = 24'hfffc0c; // Transfer count.
  localparam logic [23:0] MODE_CTRL_OFS  = 24'hfffc14; // Channel mode control.
  localparam logic [23:0] ADDR_CTRL_OFS  = 24'hfffc18; // Channel address control.
  localparam logic [23:0] REQ_SEL_OFS    = 24'hfffd20; // Module request select.
  localparam logic [23:0] SER_CTRL_OFS   = 24'hfffd30; // Serial transmit enables.
  localparam logic [23:0] IRQ_STAT_OFS   = 24'hfffd34; // Sticky event status.
  localparam logic [23:0] IRQ_MASK_OFS   = 24'hfffd38; // Event mask.

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int XFER_EN_BIT     = 31; // Channel transfer enable.
  localparam int ESC_FLAG_BIT    = 17; // Escape flag.
  localparam int END_FLAG_BIT    = 16; // Count end flag.
  localparam int ESC_IE_BIT      = 9;  // Escape interrupt enable.
  localparam int END_IE_BIT      = 8;  // Count end interrupt enable.
  localparam int ACT_SRC_LSB     = 6;  // Activation source field, bits 7:6.
  localparam int FLAG_ACK_BIT    = 5;  // Source flag acknowledge.
  localparam int ADDR_MODE_BIT   = 31; // Address mode select.
  localparam int SRC_MODE_LSB    = 20; // Source update field, bits 21:20.
  localparam int DST_MODE_LSB    = 16; // Destination update field, bits 17:16.
  localparam int TX_EMPTY_IE_BIT = 7;  // Transmit empty interrupt enable.
  localparam int TX_FIN_IE_BIT   = 2;  // Transmit finish interrupt enable.
  localparam int EV_END          = 0;  // Status bit: count end.
  localparam int EV_ESC          = 1;  // Status bit: escape.
  localparam int EV_TXFIN        = 2;  // Status bit: transmit finish.

  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [1:0] ACT_PERIPH   = 2'h2; // Peripheral interrupt activation.
  localparam logic [1:0] UPD_FIXED    = 2'h0; // Address held.
  localparam logic [1:0] UPD_INC      = 2'h2; // Address incremented.
  localparam logic [1:0] UPD_DEC      = 2'h3; // Address decremented.
  localparam logic [7:0] TX_EMPTY_SEL = 8'h92; // Serial 0 transmit empty (146).
  localparam logic [31:0] REG_RST     = 32'h0000_0000; // All registers clear.
  localparam logic [2:0]  EV_RST      = 3'h0; // Status and mask clear.

  // Channel sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_STEP} chan_st_t;

  // One transfer unit handed to the memory mover.
  typedef struct packed {
    logic        valid;  // Unit pending.
    logic        single; // Single address operation.
    logic [31:0] src;    // Read address.
    logic [31:0] dst;    // Write address.
  } xfer_t;

endpackage : dma_tx_pkg

// ===== core/dma_addr_next.sv
// Address update stage for one side of the channel.
// Assumes byte transfer units; purely combinational.
`timescale 1ns/10ps
module dma_addr_next
  import dma_tx_pkg::*;
(
  input  wire logic [31:0] addr,     // Current address.
  input  wire logic [1:0]  mode,     // Update mode field.
  output logic      [31:0] addr_nxt  // Address after one unit.
);

  // ************************************************************
  // Update selection
  // ************************************************************
  // Reserved code 01 behaves as fixed, so a stray setting never runs away.
  always_comb begin
    case (mode)
      UPD_INC: addr_nxt = addr + 32'h1;   // Step upward.
      UPD_DEC: addr_nxt = addr - 32'h1;   // Step downward.
      default: addr_nxt = addr;           // Held in place.
    endcase
  end

endmodule : dma_addr_next

// ===== core/dma_tx_channel.sv
// Configuration, control and sequencing of one DMA channel feeding a
// serial transmitter. Assumes an AHB-Lite master on the same clock and
// a memory mover that acknowledges each unit with xfer_done.
`timescale 1ns/10ps

// Function
// - Escape request only while escape enable set.
// - Count end request only while enable set.
// - Source code 10 selects peripheral activation.
// - Acknowledge bit decides clearing requester's flag.
// - Address mode bit: zero dual, one single.
// - Source update 10 increments after each unit.
// - Destination update 00 keeps address fixed.
// - Selector picks request; 146 is transmit empty.
// - Transmit empty request needs its enable.
// - Transmit finish request needs its enable.
// - Flags clear on written zero; one ignored.
// - Transfers only while channel transfer enable set.
// - Count exhaustion ends transfer, raises end flag.
module dma_tx_channel
  import dma_tx_pkg::*;
#(
  parameter int ADDR_W = 32                  // Bus address width.
)(
  input  wire logic              core_clk,        // System clock.
  input  wire logic              rst_n,           // Synchronous reset, active low.
  input  wire logic              hsel,            // Slave select.
  input  wire logic [ADDR_W-1:0] haddr,           // Byte address.
  input  wire logic [1:0]        htrans,          // Transfer type.
  input  wire logic              hwrite,          // Write when high.
  input  wire logic [2:0]        hsize,           // Transfer size.
  input  wire logic [31:0]       hwdata,          // Write data.
  input  wire logic              hready,          // Bus ready.
  output logic                   hreadyout,       // Slave ready.
  output logic                   hresp,           // Always OKAY.
  output logic [31:0]            hrdata,          // Read data.
  input  wire logic [255:0]      periph_req,      // On-chip module requests.
  input  wire logic              tx_empty_raw,    // Transmitter data empty.
  input  wire logic              tx_finish_raw,   // Transmitter finished.
  input  wire logic              xfer_done,       // Mover finished the unit.
  output xfer_t                  xfer,            // Unit to move.
  output logic                   src_flag_clear,  // Clear requester flag, pulse.
  output logic                   tx_empty_request,// Gated transmit empty request.
  output logic                   tx_finish_irq,   // Gated transmit finish request.
  output logic                   irq              // Level interrupt.
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ADDR_W < 24) begin : g_addr_chk
    $error("ADDR_W must cover the 24-bit register map");
  end

  // ************************************************************
  // State
  // ************************************************************
  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    chan_st_t    st;        // Sequencer state.
    logic        ph_wr;     // Data phase is a write.
    logic [23:0] ph_addr;   // Captured address.
    logic [31:0] src;       // Source address.
    logic [31:0] dst;       // Destination address.
    logic [31:0] count;     // Units still to move.
    logic [31:0] mode;      // Mode control.
    logic [31:0] actl;      // Address control.
    logic [7:0]  sel;       // Module request selector.
    logic [7:0]  ser;       // Serial transmit enables.
    logic [2:0]  stat;      // Sticky events.
    logic [2:0]  mask;      // Event mask.
    logic        rdy;       // hreadyout.
    logic [31:0] rdata;     // hrdata.
    xfer_t       xfer;      // Unit output.
    logic        ack;       // Flag clear pulse.
    logic        txe;       // Gated transmit empty.
    logic        txf;       // Gated transmit finish.
    logic        irq;       // Interrupt level.
  } state_t;

  state_t s_q;              // Registered state.
  state_t s_d;              // Next state.
  logic [31:0] src_nxt;     // Source after one unit.
  logic [31:0] dst_nxt;     // Destination after one unit.

  // ************************************************************
  // Address update stages
  // ************************************************************
  dma_addr_next u_src_next (
    .addr     (s_q.src),
    .mode     (s_q.actl[SRC_MODE_LSB+:2]),
    .addr_nxt (src_nxt)
  );

  dma_addr_next u_dst_next (
    .addr     (s_q.dst),
    .mode     (s_q.actl[DST_MODE_LSB+:2]),
    .addr_nxt (dst_nxt)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Bus access, sequencing and events are folded into one process so
  // that the precedence between software writes and hardware sets is
  // visible in one place: hardware sets are applied last and win.
  always_comb begin
    logic        take;      // Address phase accepted.
    logic        wr;        // Data-phase write strobe.
    logic        sel_req;   // Selected activation request.
    logic        go;        // Request accepted this cycle.
    logic        ev_end;    // Count ran out.
    logic        ev_esc;    // Channel stopped mid-run.
    logic [2:0]  ev;        // Events this cycle.
    logic [2:0]  w1c;       // Status bits cleared by software.
    logic [255:0] reqs;     // Request vector with serial bit merged.
    take    = 1'b0;
    wr      = 1'b0;
    sel_req = 1'b0;
    go      = 1'b0;
    ev_end  = 1'b0;
    ev_esc  = 1'b0;
    ev      = 3'h0;
    w1c     = 3'h0;
    reqs    = periph_req;
    s_d     = s_q;
    s_d.ack = 1'b0;

    // Serial transmitter request gating.
    s_d.txe = tx_empty_raw & s_q.ser[TX_EMPTY_IE_BIT];
    s_d.txf = tx_finish_raw & s_q.ser[TX_FIN_IE_BIT];

    // The gated transmit empty request occupies its selector slot.
    reqs[TX_EMPTY_SEL] = s_q.txe;
    sel_req = reqs[s_q.sel];

    // Software write in the data phase.
    wr = s_q.ph_wr;
    if (wr) begin
      case (s_q.ph_addr)
        SRC_ADDR_OFS:  s_d.src   = hwdata;
        DST_ADDR_OFS:  s_d.dst   = hwdata;
        COUNT_OFS:     s_d.count = hwdata;
        MODE_CTRL_OFS: begin
          s_d.mode = {hwdata[31:18], s_q.mode[17:16], hwdata[15:0]};
          // Flags only clear on a written zero.
          s_d.mode[ESC_FLAG_BIT] = s_q.mode[ESC_FLAG_BIT] & hwdata[ESC_FLAG_BIT];
          s_d.mode[END_FLAG_BIT] = s_q.mode[END_FLAG_BIT] & hwdata[END_FLAG_BIT];
          // Dropping the enable with units left is an escape.
          ev_esc = s_q.mode[XFER_EN_BIT] & ~hwdata[XFER_EN_BIT] & (s_q.count != 32'h0);
        end
        ADDR_CTRL_OFS: s_d.actl = hwdata;
        REQ_SEL_OFS:   s_d.sel  = hwdata[7:0];
        SER_CTRL_OFS:  s_d.ser  = hwdata[7:0];
        IRQ_STAT_OFS:  w1c      = hwdata[2:0];
        IRQ_MASK_OFS:  s_d.mask = hwdata[2:0];
        default:       ;  // Unmapped writes are dropped.
      endcase
    end

    // Channel sequencer.
    case (s_q.st)
      ST_IDLE: begin
        // Peripheral activation with the channel enabled.
        go = s_q.mode[XFER_EN_BIT] & (s_q.mode[ACT_SRC_LSB+:2] == ACT_PERIPH)
             & sel_req & (s_q.count != 32'h0);
        if (go) begin
          s_d.st          = ST_MOVE;
          s_d.xfer.valid  = 1'b1;
          s_d.xfer.src    = s_q.src;
          s_d.xfer.dst    = s_q.dst;
          s_d.xfer.single = s_q.actl[ADDR_MODE_BIT];
          s_d.ack         = s_q.mode[FLAG_ACK_BIT];
        end
      end
      ST_MOVE: begin
        // No further request is taken until this unit completes.
        if (xfer_done) begin
          s_d.xfer.valid = 1'b0;
          s_d.st         = ST_STEP;
        end
      end
      ST_STEP: begin
        // Addresses advance per their update fields.
        s_d.src   = src_nxt;
        s_d.dst   = dst_nxt;
        s_d.count = s_q.count - 32'h1;
        s_d.st    = ST_IDLE;
        if (s_q.count == 32'h1) begin
          // Last unit: stop the channel and flag the end.
          ev_end = 1'b1;
          s_d.mode[XFER_EN_BIT] = 1'b0;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Hardware flag sets override a same-cycle software clear.
    if (ev_end) s_d.mode[END_FLAG_BIT] = 1'b1;
    if (ev_esc) s_d.mode[ESC_FLAG_BIT] = 1'b1;

    // Requests reach the status only through their enables.
    ev[EV_END]   = ev_end & s_q.mode[END_IE_BIT];
    ev[EV_ESC]   = ev_esc & s_q.mode[ESC_IE_BIT];
    ev[EV_TXFIN] = s_q.txf & ~s_q.stat[EV_TXFIN];
    s_d.stat     = (s_q.stat & ~w1c) | ev;
    s_d.irq      = |(s_q.stat & s_q.mask);

    // Address phase: capture and prepare read data for a zero-wait answer.
    take       = hsel & htrans[1] & hready;
    s_d.ph_wr  = take & hwrite;
    s_d.ph_addr = haddr[23:0];
    s_d.rdy    = 1'b1;
    if (take & ~hwrite) begin
      case (haddr[23:0])
        SRC_ADDR_OFS:  s_d.rdata = s_d.src;
        DST_ADDR_OFS:  s_d.rdata = s_d.dst;
        COUNT_OFS:     s_d.rdata = s_d.count;
        MODE_CTRL_OFS: s_d.rdata = s_d.mode;
        ADDR_CTRL_OFS: s_d.rdata = s_d.actl;
        REQ_SEL_OFS:   s_d.rdata = {24'h0, s_d.sel};
        SER_CTRL_OFS:  s_d.rdata = {24'h0, s_d.ser};
        IRQ_STAT_OFS:  s_d.rdata = {29'h0, s_d.stat};
        IRQ_MASK_OFS:  s_d.rdata = {29'h0, s_d.mask};
        default:       s_d.rdata = 32'h0;   // Unmapped reads give zero.
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.mode  <= REG_RST;
      s_q.actl  <= REG_RST;
      s_q.stat  <= EV_RST;
      s_q.mask  <= EV_RST;
      s_q.rdy   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout        = s_q.rdy;
  assign hresp            = 1'b0;
  assign hrdata           = s_q.rdata;
  assign xfer             = s_q.xfer;
  assign src_flag_clear   = s_q.ack;
  assign tx_empty_request = s_q.txe;
  assign tx_finish_irq    = s_q.txf;
  assign irq              = s_q.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Write of one leaves the end flag untouched unless hardware sets it.
  flag_keep_a: assert property ((s_q.ph_wr && s_q.ph_addr == MODE_CTRL_OFS
      && hwdata[END_FLAG_BIT] && s_q.st != ST_STEP)
      |=> s_q.mode[END_FLAG_BIT] == $past(s_q.mode[END_FLAG_BIT]))
    else $error("end flag changed on a written one");

  zero_clear_a: assert property ((s_q.ph_wr && s_q.ph_addr == MODE_CTRL_OFS
      && !hwdata[END_FLAG_BIT] && s_q.st != ST_STEP)
      |=> !s_q.mode[END_FLAG_BIT])
    else $error("end flag not cleared by a written zero");

  // The status bit is set from the enable seen one cycle before its rise.
  end_gate_a: assert property ($rose(s_q.stat[EV_END])
      |-> $past(s_q.mode[END_IE_BIT]))
    else $error("count end status without its enable");

  esc_gate_a: assert property ($rose(s_q.stat[EV_ESC])
      |-> $past(s_q.mode[ESC_IE_BIT]))
    else $error("escape status without its enable");

  start_cond_a: assert property ($rose(s_q.xfer.valid)
      |-> $past(s_q.mode[XFER_EN_BIT]) && $past(s_q.mode[7:6]) == ACT_PERIPH)
    else $error("unit started while channel not armed");

  one_unit_a: assert property (s_q.st == ST_MOVE && xfer_done
      |=> s_q.st == ST_STEP ##1 s_q.st == ST_IDLE)
    else $error("unit did not close in two cycles");

  ack_pulse_a: assert property ($rose(s_q.xfer.valid)
      |-> s_q.ack == $past(s_q.mode[FLAG_ACK_BIT]))
    else $error("flag clear does not follow acknowledge bit");

  single_mode_a: assert property ($rose(s_q.xfer.valid)
      |-> s_q.xfer.single == $past(s_q.actl[ADDR_MODE_BIT]))
    else $error("address mode not carried to the unit");

  src_inc_a: assert property (s_q.st == ST_STEP && s_q.actl[21:20] == UPD_INC
      && !s_q.ph_wr |=> s_q.src == $past(s_q.src) + 32'h1)
    else $error("source address did not increment");

  dst_fix_a: assert property (s_q.st == ST_STEP && s_q.actl[17:16] == UPD_FIXED
      && !s_q.ph_wr |=> s_q.dst == $past(s_q.dst))
    else $error("fixed destination address moved");

  count_end_a: assert property (s_q.st == ST_STEP && s_q.count == 32'h1
      |=> !s_q.mode[XFER_EN_BIT] && s_q.mode[END_FLAG_BIT] && s_q.count == 32'h0)
    else $error("count exhaustion did not stop the channel");

  txe_gate_a: assert property (s_q.txe |-> $past(s_q.ser[TX_EMPTY_IE_BIT])
      && $past(tx_empty_raw))
    else $error("transmit empty request without enable");

  txf_gate_a: assert property (s_q.txf |-> $past(s_q.ser[TX_FIN_IE_BIT]))
    else $error("transmit finish request without enable");

  sel_map_a: assert property ($rose(s_q.xfer.valid)
      && $past(s_q.sel) == TX_EMPTY_SEL |-> $past(s_q.txe))
    else $error("selected serial request was not active");

  run_c: cover property ($rose(s_q.xfer.valid) ##[1:20] s_q.st == ST_STEP);
  end_c: cover property ($rose(s_q.mode[END_FLAG_BIT]));
  esc_c: cover property ($rose(s_q.mode[ESC_FLAG_BIT]));
  irq_c: cover property ($rose(irq));

endmodule : dma_tx_channel

// ===== verif/tx_partner.sv
// Serial transmitter and memory mover standing beside the DMA channel.
// Assumes the channel's xfer handshake on the one system clock.
`timescale 1ns/10ps
module tx_partner
  import dma_tx_pkg::*;
(
  input  wire logic  core_clk,      // System clock.
  input  wire logic  rst_n,         // Synchronous reset, active low.
  input  wire logic  slow,          // Wait three cycles before done.
  input  wire logic  fin,           // Transmitter finished level.
  input  wire xfer_t xfer,          // Unit from the channel.
  input  wire logic  flag_clear,    // Clear the empty flag, pulse.
  output logic       tx_empty_raw,  // Data register empty.
  output logic       tx_finish_raw, // Transmission finished.
  output logic       xfer_done,     // Unit moved, pulse.
  output int         units,         // Units moved so far.
  output int         clears,        // Flag clears seen so far.
  output xfer_t      last           // Last unit moved.
);
  logic [2:0] wait_q; // Cycles left before done.
  logic       sent_q; // Done already given for this unit.

  assign tx_finish_raw = fin;

  // ************************************************************
  // Mover and flag
  // ************************************************************
  // Done is given once per unit; a repeat would count a unit twice.
  always_ff @(posedge core_clk) begin
    xfer_done <= 1'b0;
    if (!rst_n) begin
      tx_empty_raw <= 1'b1;
      sent_q       <= 1'b0;
      wait_q       <= 3'h0;
      units        <= 0;
      clears       <= 0;
    end else begin
      if (flag_clear) begin
        tx_empty_raw <= 1'b0;
        clears       <= clears + 1;
      end
      if (!xfer.valid) begin
        sent_q <= 1'b0;
        wait_q <= slow ? 3'h3 : 3'h0;
      end else if (!sent_q && wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end else if (!sent_q) begin
        xfer_done    <= 1'b1;
        sent_q       <= 1'b1;
        units        <= units + 1;
        last         <= xfer;
        tx_empty_raw <= 1'b1;
      end
    end
  end
endmodule : tx_partner

// ===== verif/tb.sv
// Self-checking bench for the serial-transmit DMA channel.
// Assumes the partner model in tx_partner.sv and zero-wait registers.
`timescale 1ns/10ps
module tb;
  import dma_tx_pkg::*;
  logic         core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [255:0] periph_req;
  logic         tx_empty_raw, tx_finish_raw, xfer_done, src_flag_clear;
  logic         tx_empty_request, tx_finish_irq, irq, slow, fin;
  xfer_t        xfer, last;
  int           units, clears, failures, n_checks;

  dma_tx_channel i_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periph_req(periph_req),
    .tx_empty_raw(tx_empty_raw), .tx_finish_raw(tx_finish_raw), .xfer_done(xfer_done),
    .xfer(xfer), .src_flag_clear(src_flag_clear), .tx_empty_request(tx_empty_request),
    .tx_finish_irq(tx_finish_irq), .irq(irq));
  tx_partner i_far (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .fin(fin),
    .xfer(xfer), .flag_clear(src_flag_clear), .tx_empty_raw(tx_empty_raw),
    .tx_finish_raw(tx_finish_raw), .xfer_done(xfer_done), .units(units),
    .clears(clears), .last(last));

  always #5 core_clk = ~core_clk;

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Waits for hready under a bound; a hung slave ends the run.
  task automatic ready_edge();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask : ready_edge

  task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {8'h00, a};
    htrans <= 2'h2;
    hwrite <= w;
    ready_edge();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ready_edge();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [31:0] exp, input string name);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(name, exp, v);
  endtask : rd

  // Polls the count until it runs out; a stuck channel ends the run.
  task automatic count_zero();
    logic [31:0] v;
    int          n;
    n = 0;
    v = 32'h1;
    while (v !== 32'h0 && n < 100) begin
      bus(1'b0, COUNT_OFS, 32'h0, v);
      n++;
    end
    chk("count run out", 32'h0, v);
    if (v !== 32'h0) wrap_up();
  endtask : count_zero

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rd(MODE_CTRL_OFS, REG_RST, "mode reset");
    rd(ADDR_CTRL_OFS, REG_RST, "addr ctrl reset");
    wr(REQ_SEL_OFS, 32'hffff_ff92);
    rd(REQ_SEL_OFS, 32'h0000_0092, "selector");
    wr(24'hfffc30, 32'h1234_5678);
    rd(24'hfffc30, 32'h0, "unmapped");
    chk("bus response", 32'h0, {31'h0, hresp});
    $display("test regs done");
  endtask : t_regs

  task automatic t_serial();
    fin <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(SER_CTRL_OFS, {24'h0, i[1], 4'h0, i[0], 2'h0});
      repeat (2) @(posedge core_clk);
      chk("tx empty request", {31'h0, i[1]}, {31'h0, tx_empty_request});
      chk("tx finish request", {31'h0, i[0]}, {31'h0, tx_finish_irq});
    end
    fin <= 1'b0;
    rd(IRQ_STAT_OFS, 32'h4, "finish status");
    wr(IRQ_STAT_OFS, 32'h4);
    rd(IRQ_STAT_OFS, 32'h0, "finish status cleared");
    $display("test serial done");
  endtask : t_serial

  task automatic t_stream();
    wr(SRC_ADDR_OFS, 32'h100);
    wr(DST_ADDR_OFS, 32'h200);
    wr(COUNT_OFS, 32'h3);
    wr(ADDR_CTRL_OFS, 32'h0020_0000);
    wr(REQ_SEL_OFS, {24'h0, TX_EMPTY_SEL});
    wr(IRQ_MASK_OFS, 32'h1);
    wr(MODE_CTRL_OFS, 32'h8000_01a0);
    count_zero();
    chk("units", 32'h3, units);
    chk("flag clears", 32'h3, clears);
    chk("last src", 32'h102, last.src);
    chk("last dst", 32'h200, last.dst);
    chk("single", 32'h0, {31'h0, last.single});
    rd(SRC_ADDR_OFS, 32'h103, "src after run");
    rd(MODE_CTRL_OFS, 32'h0001_01a0, "end flag");
    chk("irq on end", 32'h1, {31'h0, irq});
    wr(MODE_CTRL_OFS, 32'h0001_01a0);
    rd(MODE_CTRL_OFS, 32'h0001_01a0, "flag after one");
    wr(MODE_CTRL_OFS, 32'h0000_01a0);
    rd(MODE_CTRL_OFS, 32'h0000_01a0, "flag after zero");
    // The interrupt level follows status and mask one cycle late.
    wr(IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFS, 32'h1);
    wr(IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test stream done");
  endtask : t_stream

  // Slow mover, acknowledge off, single address, decrementing source, another selector.
  task automatic t_other();
    int u0;
    int c0;
    u0 = units;
    c0 = clears;
    slow <= 1'b1;
    wr(COUNT_OFS, 32'h2);
    wr(ADDR_CTRL_OFS, 32'h8030_0000);
    wr(REQ_SEL_OFS, 32'h05);
    wr(MODE_CTRL_OFS, 32'h8000_0080);
    repeat (20) @(posedge core_clk);
    chk("units unselected", u0, units);
    periph_req <= 256'h20;
    count_zero();
    chk("units selected", u0 + 2, units);
    chk("clears ack off", c0, clears);
    chk("single", 32'h1, {31'h0, last.single});
    rd(SRC_ADDR_OFS, 32'h101, "src after decrement");
    rd(IRQ_STAT_OFS, 32'h0, "end ie off");
    periph_req <= 256'h0;
    slow <= 1'b0;
    $display("test other done");
  endtask : t_other

  task automatic t_escape();
    int u0;
    u0 = units;
    wr(COUNT_OFS, 32'h4);
    wr(REQ_SEL_OFS, {24'h0, TX_EMPTY_SEL});
    wr(MODE_CTRL_OFS, 32'h0000_0280);
    repeat (10) @(posedge core_clk);
    chk("units disabled", u0, units);
    wr(MODE_CTRL_OFS, 32'h8000_0200);
    repeat (10) @(posedge core_clk);
    chk("units source 00", u0, units);
    wr(MODE_CTRL_OFS, 32'h0000_0200);
    rd(MODE_CTRL_OFS, 32'h0002_0200, "escape flag");
    rd(IRQ_STAT_OFS, 32'h2, "escape status");
    wr(IRQ_STAT_OFS, 32'h2);
    wr(MODE_CTRL_OFS, 32'h8000_0000);
    wr(MODE_CTRL_OFS, 32'h0000_0000);
    rd(IRQ_STAT_OFS, 32'h0, "escape ie off");
    $display("test escape done");
  endtask : t_escape

  initial begin
    core_clk   = 1'b0;
    rst_n      = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    periph_req = 256'h0;
    slow       = 1'b0;
    fin        = 1'b0;
    failures   = 0;
    n_checks   = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_serial();
    t_stream();
    t_other();
    t_escape();
    wrap_up();
  end
endmodule : tb
